// ===== hdl/timer_pkg.sv
// Shared constants and carriers for the capture/compare timer
package timer_pkg;

    // Register byte offsets in the control area
    localparam logic [7:0] OFS_CONTROL = 8'h12;
    localparam logic [7:0] OFS_STATUS  = 8'h13;
    localparam logic [7:0] OFS_CAP_HI  = 8'h14;
    localparam logic [7:0] OFS_CAP_LO  = 8'h15;
    localparam logic [7:0] OFS_CMP_HI  = 8'h16;
    localparam logic [7:0] OFS_CMP_LO  = 8'h17;
    localparam logic [7:0] OFS_CNT_HI  = 8'h18;
    localparam logic [7:0] OFS_CNT_LO  = 8'h19;
    localparam logic [7:0] OFS_ALT_HI  = 8'h1a;
    localparam logic [7:0] OFS_ALT_LO  = 8'h1b;

    // Control field positions
    localparam int BIT_CAP_IE = 7;
    localparam int BIT_CMP_IE = 6;
    localparam int BIT_OVF_IE = 5;
    localparam int BIT_EDGE   = 1;
    localparam int BIT_LEVEL  = 0;
    localparam logic [7:0] CONTROL_MASK = 8'he3;

    // Status field positions
    localparam int BIT_CAP_F = 7;
    localparam int BIT_CMP_F = 6;
    localparam int BIT_OVF_F = 5;

    // Reset values
    localparam logic [7:0]  CONTROL_RST = 8'h00;
    localparam logic [15:0] COUNT_RST   = 16'h0000;
    localparam logic [15:0] COMPARE_RST = 16'hffff;
    localparam logic [15:0] CAPTURE_RST = 16'h0000;
    localparam logic        PIN_RST     = 1'b0;

    // Prescaler ratio
    localparam int         PRESCALE_DIV  = 4;
    localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE_DIV - 1);

    // One processor bus cycle toward the timer
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_type;

endpackage : timer_pkg

// ===== hdl/timer_prescaler.sv
// Divide-by-four prescaler giving the counter its advance enable
`timescale 1ns/1ps
module timer_prescaler
    import timer_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic stop,
    output logic      tick
);

    typedef struct packed {
        logic [1:0] div;
    } pre_state_type;

    pre_state_type st_q;
    pre_state_type st_d;

    // Phase held while stopped, so no partial period is lost
    always_comb
    begin
        st_d = st_q;
        if (!stop)
        begin
            st_d.div = st_q.div + 2'h1;
        end
    end

    // One pulse per four clocks, none in stop
    assign tick = (st_q.div == PRESCALE_LAST) && !stop;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

endmodule : timer_prescaler

// ===== hdl/capture_edge_detect.sv
// Synchroniser and selectable edge detector for the capture pin
`timescale 1ns/1ps
module capture_edge_detect
    import timer_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic capture_input_pin,
    input  wire logic capture_edge_select,
    output logic      edge_seen
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } edge_state_type;

    edge_state_type st_q;
    edge_state_type st_d;

    // Two flops, then a history flop; meta feeds only sync
    always_comb
    begin
        st_d      = st_q;
        st_d.meta = capture_input_pin;
        st_d.sync = st_q.meta;
        st_d.prev = st_q.sync;
    end

    // One pulse per qualifying edge
    assign edge_seen = capture_edge_select ?
                       (st_q.sync && !st_q.prev) :
                       (!st_q.sync && st_q.prev);

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

endmodule : capture_edge_detect

// ===== hdl/capture_compare_timer.sv
// Capture/compare timer with byte registers on the processor bus
// Operation
// - Counter of 16 bits advances once every four clocks via prescaler.
// - Counter high read latches low byte for a matching later read.
// - Alternate counter location reads without clearing overflow flag.
// - Capture flag with capture enable bit 7 requests interrupt.
// - Compare flag with compare enable bit 6 requests interrupt.
// - Overflow flag with overflow enable bit 5 requests interrupt.
// - Control bit 1 picks rising (1) or falling (0) capture edge.
// - Compare match drives compare pin to control bit 0 level.
// - Selected capture edge sets status bit 7.
// - Status read then capture low read clears capture flag.
// - Counter equal to compare register sets status bit 6.
// - Status read then compare low read or write clears compare flag.
// - Counter wrap from all ones to zero sets status bit 5.
// - Status read then primary counter low read clears overflow flag.
// - Read-only capture register holds counter plus one at capture.
// - Compare match updates compare pin as well as the flag.
// - Stop freezes the prescaler and counter; capture still works; reset leaving stop restores reset state.
// - Timer runs in wait; enabled interrupt serves as wake request.
// - Ten byte registers: control, status, counter, alternate, capture, compare.
`timescale 1ns/1ps
module capture_compare_timer
    import timer_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire bus_req_type bus_req,
    output logic [7:0]       bus_rdata,
    input  wire logic        stop,
    input  wire logic        capture_input_pin,
    output logic             compare_output_pin,
    output logic             timer_irq
);

    typedef struct packed {
        logic [7:0]  control;
        logic        cap_f;
        logic        cmp_f;
        logic        ovf_f;
        logic        arm_cap;
        logic        arm_cmp;
        logic        arm_ovf;
        logic [15:0] count;
        logic [7:0]  lo_buf;
        logic        lo_held;
        logic [7:0]  alt_buf;
        logic        alt_held;
        logic [15:0] capture;
        logic [15:0] compare;
        logic        pin;
        logic        irq;
        logic [7:0]  rdata;
    } timer_state_type;

    localparam timer_state_type STATE_RST = '{
        control:  CONTROL_RST,
        count:    COUNT_RST,
        capture:  CAPTURE_RST,
        compare:  COMPARE_RST,
        pin:      PIN_RST,
        default:  '0
    };

    timer_state_type st_q;
    timer_state_type st_d;

    logic        tick;
    logic        cap_evt;
    logic        cmp_evt;
    logic        ovf_evt;
    logic [15:0] count_next;

    // Bus decode helpers
    function automatic logic rd_hit(bus_req_type r, logic [7:0] ofs);
        return r.rd && (r.addr == ofs);
    endfunction : rd_hit

    function automatic logic wr_hit(bus_req_type r, logic [7:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction : wr_hit

    timer_prescaler u_prescaler (
        .mclk  (mclk),
        .rst_b (rst_b),
        .stop  (stop),
        .tick  (tick)
    );

    capture_edge_detect u_edge (
        .mclk                (mclk),
        .rst_b               (rst_b),
        .capture_input_pin   (capture_input_pin),
        .capture_edge_select (st_q.control[BIT_EDGE]),
        .edge_seen           (cap_evt)
    );

    // Hardware events of this clock
    assign count_next = st_q.count + 16'h0001;
    assign ovf_evt    = tick && (st_q.count == 16'hffff);
    assign cmp_evt    = tick && (count_next == st_q.compare);

    logic rd_status;
    logic rd_cap_lo;
    logic acc_cmp_lo;
    logic rd_cnt_hi;
    logic rd_cnt_lo;
    logic rd_alt_lo;

    assign rd_status  = rd_hit(bus_req, OFS_STATUS);
    assign rd_cap_lo  = rd_hit(bus_req, OFS_CAP_LO);
    assign acc_cmp_lo = rd_hit(bus_req, OFS_CMP_LO) ||
                        wr_hit(bus_req, OFS_CMP_LO);
    assign rd_cnt_hi  = rd_hit(bus_req, OFS_CNT_HI);
    assign rd_cnt_lo  = rd_hit(bus_req, OFS_CNT_LO);
    assign rd_alt_lo  = rd_hit(bus_req, OFS_ALT_LO);

    // Whole next state; clears come first so a same-cycle set wins
    always_comb
    begin
        st_d = st_q;

        // Counter advance; stop holds it through the prescaler
        if (tick)
        begin
            st_d.count = count_next;
        end

        // Register writes
        if (wr_hit(bus_req, OFS_CONTROL))
        begin
            st_d.control = bus_req.wdata & CONTROL_MASK;
        end
        if (wr_hit(bus_req, OFS_CMP_HI))
        begin
            st_d.compare[15:8] = bus_req.wdata;
        end
        if (wr_hit(bus_req, OFS_CMP_LO))
        begin
            st_d.compare[7:0] = bus_req.wdata;
        end

        // Read data mux over the ten locations
        st_d.rdata = 8'h00;
        if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                OFS_CONTROL: st_d.rdata = st_q.control;
                OFS_STATUS:  st_d.rdata = {st_q.cap_f, st_q.cmp_f,
                                           st_q.ovf_f, 5'h00};
                OFS_CAP_HI:  st_d.rdata = st_q.capture[15:8];
                OFS_CAP_LO:  st_d.rdata = st_q.capture[7:0];
                OFS_CMP_HI:  st_d.rdata = st_q.compare[15:8];
                OFS_CMP_LO:  st_d.rdata = st_q.compare[7:0];
                OFS_CNT_HI,
                OFS_ALT_HI:  st_d.rdata = st_q.count[15:8];
                OFS_CNT_LO:  st_d.rdata = st_q.lo_held ?
                                          st_q.lo_buf : st_q.count[7:0];
                OFS_ALT_LO:  st_d.rdata = st_q.alt_held ?
                                          st_q.alt_buf : st_q.count[7:0];
                default:     st_d.rdata = 8'h00;
            endcase
        end

        // High read freezes low byte; the two locations keep own buffers
        if (rd_cnt_hi)
        begin
            st_d.lo_buf  = st_q.count[7:0];
            st_d.lo_held = 1'b1;
        end
        if (rd_cnt_lo)
        begin
            st_d.lo_held = 1'b0;
        end
        if (rd_hit(bus_req, OFS_ALT_HI))
        begin
            st_d.alt_buf  = st_q.count[7:0];
            st_d.alt_held = 1'b1;
        end
        if (rd_alt_lo)
        begin
            st_d.alt_held = 1'b0;
        end

        // Status read arms only the flags it showed as set
        if (rd_status)
        begin
            st_d.arm_cap = st_q.cap_f;
            st_d.arm_cmp = st_q.cmp_f;
            st_d.arm_ovf = st_q.ovf_f;
        end

        // Second step of each clear sequence
        if (rd_cap_lo && st_q.arm_cap)
        begin
            st_d.cap_f   = 1'b0;
            st_d.arm_cap = 1'b0;
        end
        if (acc_cmp_lo && st_q.arm_cmp)
        begin
            st_d.cmp_f   = 1'b0;
            st_d.arm_cmp = 1'b0;
        end
        if (rd_cnt_lo && st_q.arm_ovf)
        begin
            st_d.ovf_f   = 1'b0;
            st_d.arm_ovf = 1'b0;
        end

        // Event sets override any clear in the same cycle
        if (cap_evt)
        begin
            st_d.cap_f   = 1'b1;
            st_d.capture = count_next;
        end
        if (cmp_evt)
        begin
            st_d.cmp_f = 1'b1;
            st_d.pin   = st_q.control[BIT_LEVEL];
        end
        if (ovf_evt)
        begin
            st_d.ovf_f = 1'b1;
        end

        // Interrupt request; also the wake source out of wait
        st_d.irq = (st_d.cap_f && st_d.control[BIT_CAP_IE]) ||
                   (st_d.cmp_f && st_d.control[BIT_CMP_IE]) ||
                   (st_d.ovf_f && st_d.control[BIT_OVF_IE]);
    end

    // Async reset returns everything, including a stopped timer
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= STATE_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign bus_rdata          = st_q.rdata;
    assign compare_output_pin = st_q.pin;
    assign timer_irq          = st_q.irq;

    // Checks on the timer's own behaviour
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_status_ovf;
        rd_status && st_q.ovf_f;
    endsequence

    sequence s_lo_read_quiet;
        rd_cnt_lo && !ovf_evt;
    endsequence

    chk_tick_spacing:
    assert property (tick |=> !tick [*3])
        else $error("prescaler pulse closer than four clocks");

    chk_count_step:
    assert property (tick |=> st_q.count == $past(st_q.count) + 16'h0001)
        else $error("counter did not advance by one");

    chk_lo_latch:
    assert property (rd_cnt_hi |=>
                     st_q.lo_held && st_q.lo_buf == $past(st_q.count[7:0]))
        else $error("low byte not latched on high read");

    chk_alt_keeps:
    assert property ((rd_alt_lo && st_q.ovf_f) |=> st_q.ovf_f)
        else $error("alternate read cleared overflow");

    chk_cap_irq:
    assert property ((st_q.cap_f && st_q.control[BIT_CAP_IE]) |-> timer_irq)
        else $error("capture interrupt missing");

    chk_cmp_irq:
    assert property ((st_q.cmp_f && st_q.control[BIT_CMP_IE]) |-> timer_irq)
        else $error("compare interrupt missing");

    chk_ovf_irq:
    assert property ((st_q.ovf_f && st_q.control[BIT_OVF_IE]) |-> timer_irq)
        else $error("overflow interrupt missing");

    chk_capture_value:
    assert property (cap_evt |=> st_q.cap_f &&
                     st_q.capture == $past(st_q.count) + 16'h0001)
        else $error("capture flag or value wrong");

    chk_cap_clear:
    assert property ((!st_q.arm_cap && st_q.cap_f) |=> st_q.cap_f)
        else $error("capture flag cleared without status read");

    chk_compare_pin:
    assert property (cmp_evt |=> st_q.cmp_f &&
                     compare_output_pin == $past(st_q.control[BIT_LEVEL]))
        else $error("compare match not applied");

    chk_cmp_clear:
    assert property ((st_q.arm_cmp && acc_cmp_lo && !cmp_evt) |=>
                     !st_q.cmp_f)
        else $error("compare flag not cleared");

    chk_ovf_wrap:
    assert property (ovf_evt |=> st_q.ovf_f && st_q.count == 16'h0000)
        else $error("overflow wrap not flagged");

    chk_ovf_clear:
    assert property ((s_status_ovf ##1 s_lo_read_quiet) |=> !st_q.ovf_f)
        else $error("overflow flag not cleared by sequence");

    chk_stop_freeze:
    assert property (stop |=> $stable(st_q.count))
        else $error("counter moved in stop");

    // Release, quiet and single-pulse checks; these catch stuck logic
    chk_cap_cleared:
    assert property ((st_q.arm_cap && rd_cap_lo && !cap_evt) |=>
                     !st_q.cap_f)
        else $error("capture flag not cleared");

    chk_lo_release:
    assert property (rd_cnt_lo |=> !st_q.lo_held)
        else $error("low byte buffer not released");

    chk_one_capture:
    assert property (cap_evt |=> !cap_evt)
        else $error("one pin edge gave two captures");

    chk_rdata_idle:
    assert property (!bus_req.rd |=> bus_rdata == 8'h00)
        else $error("read data not zero without a read");

    chk_irq_quiet:
    assert property (!((st_q.cap_f && st_q.control[BIT_CAP_IE]) ||
                       (st_q.cmp_f && st_q.control[BIT_CMP_IE]) ||
                       (st_q.ovf_f && st_q.control[BIT_OVF_IE])) |->
                     !timer_irq)
        else $error("interrupt without an enabled flag");

endmodule : capture_compare_timer

// ===== tb/event_source.sv
// Partner model: external pulse source on the capture pin
`timescale 1ns/1ps
module event_source (
    input  wire logic       go,
    input  wire logic [7:0] width,
    output logic            capture_input_pin
);
    // Idle low; pulse starts off the clock grid like a real pin
    initial
        capture_input_pin = 1'b0;
    always @(posedge go)
    begin
        #37 capture_input_pin = 1'b1;
        #(width * 100) capture_input_pin = 1'b0;
    end
endmodule : event_source

// ===== tb/capture_compare_timer_test.sv
// Self-checking bench with a reference model of the timer
`timescale 1ns/1ps
module capture_compare_timer_test;
    import timer_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        stop = 1'b0;
    logic        go = 1'b0;
    logic [7:0]  width = 8'h08;
    bus_req_type bus_req = '0;
    logic [7:0]  bus_rdata;
    logic        compare_output_pin;
    logic        timer_irq;
    logic        capture_input_pin;
    int          fail_count = 0;
    int          n_tests = 0;
    // Model state, integers only
    int ph, cnt, cmp, cap, ctl, flg, arm, pin, irq, s1, s2, s3;
    int hbuf, abuf, hv, av, rv, clr, setm, t;
    int exp_q[$];

    always #50 mclk = ~mclk;

    capture_compare_timer capture_compare_timer_i (
        .mclk(mclk), .rst_b(rst_b), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .stop(stop),
        .capture_input_pin(capture_input_pin),
        .compare_output_pin(compare_output_pin), .timer_irq(timer_irq));
    event_source event_source_i (
        .go(go), .width(width), .capture_input_pin(capture_input_pin));

    // Reference model; reads use values from before the edge
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ph = 0;
            cnt = 0;
            cmp = 'hffff;
            cap = 0;
            ctl = 0;
            flg = 0;
            arm = 0;
            pin = 0;
            irq = 0;
            hv = 0;
            av = 0;
            s1 = 0;
            s2 = 0;
            s3 = 0;
        end
        else
        begin
            clr = 0;
            setm = 0;
            if (bus_req.rd)
            begin
                case (bus_req.addr)
                    OFS_CONTROL: rv = ctl;
                    OFS_STATUS:  rv = flg;
                    OFS_CAP_HI:  rv = cap >> 8;
                    OFS_CAP_LO:  rv = cap;
                    OFS_CMP_HI:  rv = cmp >> 8;
                    OFS_CMP_LO:  rv = cmp;
                    OFS_CNT_HI:  rv = cnt >> 8;
                    OFS_CNT_LO:  rv = hv ? hbuf : cnt;
                    OFS_ALT_HI:  rv = cnt >> 8;
                    OFS_ALT_LO:  rv = av ? abuf : cnt;
                    default:     rv = 0;
                endcase
                exp_q.push_back(rv & 255);
                if (bus_req.addr == OFS_STATUS)
                    arm = arm | flg;
                if (bus_req.addr == OFS_CAP_LO)
                    clr = 'h80;
                if (bus_req.addr == OFS_CMP_LO)
                    clr = 'h40;
                if (bus_req.addr == OFS_CNT_LO)
                    clr = 'h20;
                hv = (bus_req.addr == OFS_CNT_HI) ? 1 : (bus_req.addr ==
                    OFS_CNT_LO) ? 0 : hv;
                av = (bus_req.addr == OFS_ALT_HI) ? 1 : (bus_req.addr ==
                    OFS_ALT_LO) ? 0 : av;
                hbuf = (bus_req.addr == OFS_CNT_HI) ? cnt : hbuf;
                abuf = (bus_req.addr == OFS_ALT_HI) ? cnt : abuf;
            end
            // Three-flop path: pin change is acted on at the third edge
            if (s2 != s3 && s2 == ((ctl >> 1) & 1))
            begin
                cap = (cnt + 1) & 'hffff;
                setm = 'h80;
            end
            s3 = s2;
            s2 = s1;
            s1 = capture_input_pin;
            if (!stop)
            begin
                if (ph == 3)
                begin
                    cnt = (cnt + 1) & 'hffff;
                    setm = setm | ((cnt == 0) ? 'h20 : 0);
                    if (cnt == cmp)
                    begin
                        setm = setm | 'h40;
                        pin = ctl & 1;
                    end
                end
                ph = (ph + 1) & 3;
            end
            if (bus_req.wr && bus_req.addr == OFS_CONTROL)
                ctl = bus_req.wdata & 'he3;
            if (bus_req.wr && bus_req.addr == OFS_CMP_HI)
                cmp = (cmp & 255) | (bus_req.wdata << 8);
            if (bus_req.wr && bus_req.addr == OFS_CMP_LO)
            begin
                cmp = (cmp & 'hff00) | bus_req.wdata;
                clr = 'h40;
            end
            // Set wins over clear in the same cycle
            flg = (flg & ~(clr & arm)) | setm;
            arm = arm & ~clr;
            irq = (flg & ctl & 'he0) != 0;
        end
    end

    task automatic chk_byte(input logic [7:0] got, input int exp);
        n_tests++;
        if (got !== 8'(exp))
        begin
            fail_count++;
            $display("Error %0t: read %h want %h", $time, got, 8'(exp));
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input int exp);
        n_tests++;
        if (got !== 1'(exp))
        begin
            fail_count++;
            $display("Error %0t: pin %b want %b", $time, got, 1'(exp));
        end
    endtask : chk_bit

    // Pins are compared every cycle once settled
    always @(negedge mclk)
        if (rst_b)
        begin
            chk_bit(compare_output_pin, pin);
            chk_bit(timer_irq, irq);
        end

    // Bus strobes stay up between back-to-back calls
    task automatic rd(input logic [7:0] a);
        bus_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge mclk);
        chk_byte(bus_rdata, exp_q.pop_front());
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge mclk);
    endtask : wr

    task automatic idle;
        bus_req = '0;
        @(negedge mclk);
    endtask : idle

    task automatic wait_flag(input int m);
        int k;
        for (k = 0; k < 400 && (flg & m) == 0; k++)
            @(negedge mclk);
        if (k == 400)
        begin
            fail_count++;
            stop_test();
        end
    endtask : wait_flag

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    initial
    begin
        #3000000;
        fail_count++;
        stop_test();
    end

    initial
    begin
        void'($urandom(32'hc1e3cdb2));
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        // All locations and one unmapped place, read twice
        for (int a = 'h12; a <= 'h1c; a++)
            rd(8'(a));
        for (int a = 'h12; a <= 'h1c; a++)
            rd(8'(a));
        wr(OFS_CONTROL, 8'($urandom));
        wr(OFS_STATUS, 8'hff);
        wr(OFS_CAP_LO, 8'h5a);
        rd(OFS_CONTROL);
        rd(OFS_CAP_LO);
        // Latched low byte must differ from the live one
        rd(OFS_CNT_HI);
        repeat (6) idle();
        rd(OFS_CNT_LO);
        rd(OFS_ALT_HI);
        repeat (6) idle();
        rd(OFS_ALT_LO);
        rd(OFS_CNT_LO);
        // Level 1 then 0; cleared by a read, then by a write
        for (int i = 0; i < 2; i++)
        begin
            wr(OFS_CONTROL, 8'h41 - 8'(i));
            t = cnt + 8 + $urandom % 20;
            wr(OFS_CMP_HI, 8'(t >> 8));
            wr(OFS_CMP_LO, 8'(t));
            idle();
            wait_flag('h40);
            rd(OFS_CMP_LO);
            rd(OFS_STATUS);
            if (i == 0)
                rd(OFS_CMP_LO);
            else
                wr(OFS_CMP_LO, 8'(t));
            rd(OFS_STATUS);
        end
        // Falling then rising edge; the other edge must not capture
        for (int i = 0; i < 2; i++)
        begin
            wr(OFS_CONTROL, 8'h80 | 8'(i << 1));
            width = 8'(4 + $urandom % 12);
            go = 1'b1;
            idle();
            wait_flag('h80);
            go = 1'b0;
            repeat (20) idle();
            rd(OFS_CAP_LO);
            rd(OFS_STATUS);
            rd(OFS_CAP_HI);
            rd(OFS_CAP_LO);
            rd(OFS_STATUS);
        end
        // Frozen counter, then reset ends the stop state
        stop = 1'b1;
        repeat (40) idle();
        rd(OFS_CNT_HI);
        rd(OFS_CNT_LO);
        idle();
        rst_b = 1'b0;
        @(negedge mclk);
        rst_b = 1'b1;
        stop = 1'b0;
        for (int a = 'h12; a <= 'h1b; a++)
            rd(8'(a));
        idle();
        stop_test();
    end
endmodule : capture_compare_timer_test
